// *** flag_cfg_if.sv ***
// Configuration bits passed from the register to the flag gating logic.
// Assumes both ends share clk_sys.
`timescale 1ns/100ps
`default_nettype none
interface flag_cfg_if;
  logic mask_first_high_side_underload;
  logic mask_first_low_side_underload;
  logic mask_all_underload_summary;
  logic mask_thermal_warning_summary;
  logic mirror_pwm_discharge_enable;
  modport source (
    output mask_first_high_side_underload,
    output mask_first_low_side_underload,
    output mask_all_underload_summary,
    output mask_thermal_warning_summary,
    output mirror_pwm_discharge_enable
  );
  modport sink (
    input mask_first_high_side_underload,
    input mask_first_low_side_underload,
    input mask_all_underload_summary,
    input mask_thermal_warning_summary,
    input mirror_pwm_discharge_enable
  );
endinterface : flag_cfg_if
`default_nettype wire

// *** flag_gate.sv ***
// Gates underload and thermal events onto the global summary flags.
// Assumes event inputs come from logic on clk_sys.
`timescale 1ns/100ps
`default_nettype none
module flag_gate #(
  parameter int NUM_OUTPUTS = flag_mask_pkg::NUM_OUTPUTS_DEF,
  parameter int IDX_HS1     = flag_mask_pkg::IDX_HS1_DEF,
  parameter int IDX_LS1     = flag_mask_pkg::IDX_LS1_DEF
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  // Configuration
  flag_cfg_if.sink                    cfg,
  // Events
  input  wire logic [NUM_OUTPUTS-1:0] underload_event,
  input  wire logic                   thermal_warning_event,
  input  wire logic                   oc_recovery_request,
  // Results
  output logic      [NUM_OUTPUTS-1:0] underload_status,
  output logic                        global_underload,
  output logic                        global_thermal_warning,
  output logic                        mirror_feedback_overcurrent_recovery
);
  logic [NUM_OUTPUTS-1:0] uld_d, uld_q, contrib;
  logic                   gul_d, gul_q, tw_d, tw_q, rec_d, rec_q;

  always_comb begin
    contrib = underload_event;
    contrib[IDX_HS1] = underload_event[IDX_HS1] & ~cfg.mask_first_high_side_underload;
    contrib[IDX_LS1] = underload_event[IDX_LS1] & ~cfg.mask_first_low_side_underload;
    uld_d = underload_event;
    gul_d = (|contrib) & ~cfg.mask_all_underload_summary;
    tw_d  = thermal_warning_event & ~cfg.mask_thermal_warning_summary;
    // Discharge pulses the stage, so automatic restart would fight it
    rec_d = oc_recovery_request & ~cfg.mirror_pwm_discharge_enable;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      uld_q <= '0;
      gul_q <= 1'b0;
      tw_q  <= 1'b0;
      rec_q <= 1'b0;
    end else begin
      uld_q <= uld_d;
      gul_q <= gul_d;
      tw_q  <= tw_d;
      rec_q <= rec_d;
    end
  end

  assign underload_status                     = uld_q;
  assign global_underload                     = gul_q;
  assign global_thermal_warning               = tw_q;
  assign mirror_feedback_overcurrent_recovery = rec_q;

  property p_hs1_mask;
    @(posedge clk_sys) disable iff (!reset_n)
    (cfg.mask_first_high_side_underload && underload_event == (1 << IDX_HS1))
      |=> !global_underload && underload_status[IDX_HS1];
  endproperty
  a_hs1_mask: assert property (p_hs1_mask) else $error("HS1 underload leaked to summary");

  property p_ls1_mask;
    @(posedge clk_sys) disable iff (!reset_n)
    (cfg.mask_first_low_side_underload && underload_event == (1 << IDX_LS1))
      |=> !global_underload && underload_status[IDX_LS1];
  endproperty
  a_ls1_mask: assert property (p_ls1_mask) else $error("LS1 underload leaked to summary");

  property p_independent;
    @(posedge clk_sys) disable iff (!reset_n)
    (!cfg.mask_all_underload_summary && cfg.mask_first_high_side_underload
     && !cfg.mask_first_low_side_underload && underload_event[IDX_LS1]) |=> global_underload;
  endproperty
  a_independent: assert property (p_independent) else $error("LS1 masked by HS1 mask");

  property p_mask_all;
    @(posedge clk_sys) disable iff (!reset_n)
    cfg.mask_all_underload_summary |=> !global_underload;
  endproperty
  a_mask_all: assert property (p_mask_all) else $error("Summary set while masked");

  property p_tw;
    @(posedge clk_sys) disable iff (!reset_n)
    1'b1 |=> global_thermal_warning ==
      ($past(thermal_warning_event) && !$past(cfg.mask_thermal_warning_summary));
  endproperty
  a_tw: assert property (p_tw) else $error("Thermal summary wrong");

  sequence s_discharge_held;
    cfg.mirror_pwm_discharge_enable [*2];
  endsequence
  property p_no_recovery;
    @(posedge clk_sys) disable iff (!reset_n)
    s_discharge_held |-> !mirror_feedback_overcurrent_recovery;
  endproperty
  a_no_recovery: assert property (p_no_recovery) else $error("Recovery during discharge");

  property p_pass;
    @(posedge clk_sys) disable iff (!reset_n)
    (!cfg.mask_all_underload_summary && (|(underload_event & ~((1 << IDX_HS1) | (1 << IDX_LS1)))))
      |=> global_underload;
  endproperty
  a_pass: assert property (p_pass) else $error("Underload did not reach summary");

  property p_status;
    @(posedge clk_sys) disable iff (!reset_n)
    1'b1 |=> underload_status == $past(underload_event);
  endproperty
  a_status: assert property (p_status) else $error("Own underload status wrong");

  property p_recovery;
    @(posedge clk_sys) disable iff (!reset_n)
    (oc_recovery_request && !cfg.mirror_pwm_discharge_enable)
      |=> mirror_feedback_overcurrent_recovery;
  endproperty
  a_recovery: assert property (p_recovery) else $error("Recovery enable lost");

  // Elaboration-time check: both stage indices must be distinct and in range
  if (NUM_OUTPUTS < 2 || IDX_HS1 >= NUM_OUTPUTS || IDX_LS1 >= NUM_OUTPUTS
      || IDX_HS1 == IDX_LS1) begin : g_bad_indices
    $error("flag_gate: bad output indices");
  end
endmodule : flag_gate
`default_nettype wire

// *** flag_mask_pkg.sv ***
// Constants for the global flag mask configuration register.
// Assumes one system clock; register access comes from the serial decoder.
// Function
// - High-side stage one underload mask blocks summary
// - Low-side stage one underload mask blocks summary
// - Both stage masks act independently
// - General underload mask blocks all summary
// - Thermal warning mask blocks thermal summary
// - Discharge bit enables mirror PWM discharge
// - Discharge forces mirror overcurrent recovery off
// - Fields reset to zero, unused read zero
// - Clear general mask lets underloads through
// - Underload sets own status and summary
// - Recovery enable passes on to output stage
package flag_mask_pkg;
  localparam int          ADDR_W          = 7;
  localparam int          DATA_W          = 16;
  localparam logic [6:0]  CFG_ADDR        = 7'h3F;
  localparam logic [15:0] CFG_RESET       = 16'h0000;
  localparam logic [15:0] CFG_WRITE_MASK  = 16'h00BA;
  localparam int          BIT_MASK_ALL    = 1;
  localparam int          BIT_MASK_TW     = 3;
  localparam int          BIT_MASK_LS1    = 4;
  localparam int          BIT_MASK_HS1    = 5;
  localparam int          BIT_DISCHARGE   = 7;
  localparam int          NUM_OUTPUTS_DEF = 12;
  localparam int          IDX_HS1_DEF     = 0;
  localparam int          IDX_LS1_DEF     = 1;
endpackage : flag_mask_pkg

// *** global_flag_mask_config.sv ***
// Global flag mask configuration register with its flag gating.
// Assumes the serial decoder issues single-cycle accesses on clk_sys.
`timescale 1ns/100ps
`default_nettype none
module global_flag_mask_config #(
  parameter int NUM_OUTPUTS = flag_mask_pkg::NUM_OUTPUTS_DEF,
  parameter int IDX_HS1     = flag_mask_pkg::IDX_HS1_DEF,
  parameter int IDX_LS1     = flag_mask_pkg::IDX_LS1_DEF
) (
  // Clock and reset
  input  wire logic                                clk_sys,
  input  wire logic                                reset_n,
  // Register access
  input  wire logic                                reg_wr_en,
  input  wire logic                                reg_rd_en,
  input  wire logic [flag_mask_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [flag_mask_pkg::DATA_W-1:0]    reg_wr_data,
  output logic      [flag_mask_pkg::DATA_W-1:0]    reg_rd_data,
  // Events from output stages
  input  wire logic [NUM_OUTPUTS-1:0]              underload_event,
  input  wire logic                                thermal_warning_event,
  input  wire logic                                oc_recovery_request,
  // Flags and controls
  output logic      [NUM_OUTPUTS-1:0]              underload_status,
  output logic                                     global_underload,
  output logic                                     global_thermal_warning,
  output logic                                     mirror_pwm_discharge_enable,
  output logic                                     mirror_feedback_overcurrent_recovery
);
  logic [15:0] cfg_d, cfg_q, rd_d, rd_q;
  logic        hit;

  flag_cfg_if cfg_bus ();

  function automatic logic addr_hit(input logic [flag_mask_pkg::ADDR_W-1:0] a);
    addr_hit = (a == flag_mask_pkg::CFG_ADDR);
  endfunction

  always_comb begin
    hit   = addr_hit(reg_addr);
    cfg_d = cfg_q;
    if (reg_wr_en && hit) begin
      cfg_d = reg_wr_data & flag_mask_pkg::CFG_WRITE_MASK;
    end
    // Unmapped or idle reads return zero
    rd_d = '0;
    if (reg_rd_en && hit) begin
      rd_d = cfg_q & flag_mask_pkg::CFG_WRITE_MASK;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= flag_mask_pkg::CFG_RESET;
      rd_q  <= '0;
    end else begin
      cfg_q <= cfg_d;
      rd_q  <= rd_d;
    end
  end

  assign cfg_bus.mask_first_high_side_underload = cfg_q[flag_mask_pkg::BIT_MASK_HS1];
  assign cfg_bus.mask_first_low_side_underload  = cfg_q[flag_mask_pkg::BIT_MASK_LS1];
  assign cfg_bus.mask_all_underload_summary     = cfg_q[flag_mask_pkg::BIT_MASK_ALL];
  assign cfg_bus.mask_thermal_warning_summary   = cfg_q[flag_mask_pkg::BIT_MASK_TW];
  assign cfg_bus.mirror_pwm_discharge_enable    = cfg_q[flag_mask_pkg::BIT_DISCHARGE];
  assign mirror_pwm_discharge_enable            = cfg_q[flag_mask_pkg::BIT_DISCHARGE];
  assign reg_rd_data                            = rd_q;

  flag_gate #(
    .NUM_OUTPUTS (NUM_OUTPUTS),
    .IDX_HS1     (IDX_HS1),
    .IDX_LS1     (IDX_LS1)
  ) u_gate (
    .clk_sys                              (clk_sys),
    .reset_n                              (reset_n),
    .cfg                                  (cfg_bus.sink),
    .underload_event                      (underload_event),
    .thermal_warning_event                (thermal_warning_event),
    .oc_recovery_request                  (oc_recovery_request),
    .underload_status                     (underload_status),
    .global_underload                     (global_underload),
    .global_thermal_warning               (global_thermal_warning),
    .mirror_feedback_overcurrent_recovery (mirror_feedback_overcurrent_recovery)
  );

  property p_reserved;
    @(posedge clk_sys) disable iff (!reset_n)
    1'b1 |-> (reg_rd_data & ~flag_mask_pkg::CFG_WRITE_MASK) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved bits read nonzero");

  sequence s_write_discharge;
    reg_wr_en && hit && reg_wr_data[flag_mask_pkg::BIT_DISCHARGE];
  endsequence
  property p_discharge;
    @(posedge clk_sys) disable iff (!reset_n)
    s_write_discharge |=> mirror_pwm_discharge_enable;
  endproperty
  a_discharge: assert property (p_discharge) else $error("Discharge enable not set");

  property p_readback;
    @(posedge clk_sys) disable iff (!reset_n)
    (reg_wr_en && hit) ##1 (reg_rd_en && hit && !reg_wr_en)
      |=> reg_rd_data == ($past(reg_wr_data, 2) & flag_mask_pkg::CFG_WRITE_MASK);
  endproperty
  a_readback: assert property (p_readback) else $error("Readback mismatch");

  property p_reset_zero;
    @(posedge clk_sys) $rose(reset_n) |-> cfg_q == flag_mask_pkg::CFG_RESET;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("Config not zero after reset");
endmodule : global_flag_mask_config
`default_nettype wire

// *** global_flag_mask_config_tb_top.sv ***
// Self-checking bench for the global flag mask configuration register.
// Assumes default parameters; the bench drives every port itself.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, ex, gt); end end
module global_flag_mask_config_tb_top;
  localparam int N     = flag_mask_pkg::NUM_OUTPUTS_DEF;
  localparam int LIMIT = 20000;
  // Writable positions 7, 5, 4, 3 and 1
  localparam logic [15:0] WMASK = 16'h00ba;
  logic           clk_sys     = 1'b0;
  logic           reset_n     = 1'b0;
  logic           reg_wr_en   = 1'b0;
  logic           reg_rd_en   = 1'b0;
  logic [6:0]     reg_addr    = 7'h00;
  logic [15:0]    reg_wr_data = 16'h0000;
  logic [N-1:0]   ul_ev       = '0;
  logic           tw_ev       = 1'b0;
  logic           oc_req      = 1'b0;
  wire logic [15:0]  reg_rd_data;
  wire logic [N-1:0] ul_st;
  wire logic         g_ul;
  wire logic         g_tw;
  wire logic         disch;
  wire logic         oc_rec;
  logic [15:0]    cfg = 16'h0000;
  logic [N-1:0]   one = N'(1);
  int             mismatches = 0;
  int             compares   = 0;
  int             cycles     = 0;

  global_flag_mask_config i_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .underload_event(ul_ev), .thermal_warning_event(tw_ev), .oc_recovery_request(oc_req),
    .underload_status(ul_st), .global_underload(g_ul), .global_thermal_warning(g_tw),
    .mirror_pwm_discharge_enable(disch), .mirror_feedback_overcurrent_recovery(oc_rec)
  );

  always #4 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      end_sim();
    end
  end

  task end_sim;
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim

  function automatic logic exp_ul(input logic [15:0] c, input logic [N-1:0] ev);
    logic [N-1:0] m;
    m = ev;
    if (c[5]) m[flag_mask_pkg::IDX_HS1_DEF] = 1'b0;
    if (c[4]) m[flag_mask_pkg::IDX_LS1_DEF] = 1'b0;
    return ~c[1] & (|m);
  endfunction : exp_ul

  // Write, then read back with new events, then check flags and read data
  task automatic step(input logic wr, input logic [6:0] wa, input logic [15:0] wd,
                      input logic [N-1:0] ev, input logic tw, input logic oc,
                      input logic [6:0] ra);
    @(negedge clk_sys);
    reg_wr_en   = wr;
    reg_addr    = wa;
    reg_wr_data = wd;
    if (wr && wa == flag_mask_pkg::CFG_ADDR) cfg = wd & WMASK;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b1;
    reg_addr  = ra;
    ul_ev     = ev;
    tw_ev     = tw;
    oc_req    = oc;
    @(negedge clk_sys);
    reg_rd_en = 1'b0;
    `CHK("read", (ra == flag_mask_pkg::CFG_ADDR) ? cfg : 16'h0000, reg_rd_data)
    `CHK("status", ev, ul_st)
    `CHK("global_ul", exp_ul(cfg, ev), g_ul)
    `CHK("global_tw", tw & ~cfg[3], g_tw)
    `CHK("discharge", cfg[7], disch)
    `CHK("oc_rec", oc & ~cfg[7], oc_rec)
    @(negedge clk_sys);
    `CHK("read_idle", 16'h0000, reg_rd_data)
  endtask : step

  initial begin
    logic [15:0] d;
    logic [N-1:0] ev;
    logic [6:0] wa;
    logic [6:0] ra;
    void'($urandom(32'h68b8b102));
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'b1;
    step(1'b0, 7'h00, 16'h0000, one, 1'b1, 1'b1, flag_mask_pkg::CFG_ADDR);
    // Every mask combination, reserved bits written as ones
    for (int i = 0; i < 32; i++) begin
      for (int p = 0; p < 4; p++) begin
        d = {8'hff, i[4], 1'b1, i[3], i[2], i[1], 1'b1, i[0], 1'b1};
        ev = (p == 0) ? one << flag_mask_pkg::IDX_HS1_DEF :
             (p == 1) ? one << flag_mask_pkg::IDX_LS1_DEF : (p == 2) ? one << 2 : '0;
        step(1'b1, flag_mask_pkg::CFG_ADDR, d, ev, p[0], p[1],
             flag_mask_pkg::CFG_ADDR);
      end
    end
    // Random traffic, some to unmapped addresses
    for (int k = 0; k < 300; k++) begin
      wa = ($urandom % 4 == 0) ? 7'($urandom) : flag_mask_pkg::CFG_ADDR;
      ra = ($urandom % 4 == 0) ? 7'($urandom) : flag_mask_pkg::CFG_ADDR;
      ev = N'($urandom) & N'($urandom);
      step(1'($urandom), wa, 16'($urandom), ev, 1'($urandom), 1'($urandom), ra);
    end
    // Reset in mid-run clears every field
    step(1'b1, flag_mask_pkg::CFG_ADDR, 16'hffff, one, 1'b1, 1'b1, 7'h00);
    @(negedge clk_sys);
    reset_n = 1'b0;
    cfg     = 16'h0000;
    @(negedge clk_sys);
    `CHK("discharge_rst", 1'b0, disch)
    `CHK("global_ul_rst", 1'b0, g_ul)
    reset_n = 1'b1;
    step(1'b0, 7'h00, 16'h0000, one << 1, 1'b1, 1'b1, flag_mask_pkg::CFG_ADDR);
    end_sim();
  end
endmodule : global_flag_mask_config_tb_top
`default_nettype wire
